//--- ras_pkg.sv
/*
  shared constants of the rtc action scheduler: register pages and offsets,
  reset values, range limits and indication timing.
  assumes a 100 MHz core clock and an rtc that delivers bcd hour and minute.
*/
package ras_pkg;
  // ==========================================================
  // register pages (bus device addresses) and offsets
  localparam logic [6:0] PG_CTRL = 7'h6b;
  localparam logic [6:0] PG_START = 7'h6c;
  localparam logic [6:0] PG_TIME = 7'h6d;
  localparam logic [6:0] PG_ACT = 7'h6e;
  localparam logic [7:0] OFF_SEL = 8'h16;
  localparam logic [7:0] OFF_RUN = 8'h17;
  localparam logic [7:0] OFF_ACTIVE = 8'h00;
  localparam logic [7:0] OFF_MINUTE = 8'h01;
  localparam logic [7:0] OFF_HOUR = 8'h02;
  localparam logic [7:0] OFF_DUR = 8'h00;
  localparam logic [7:0] OFF_IVL = 8'h02;
  localparam logic [7:0] OFF_MUL = 8'h03;
  localparam logic [7:0] OFF_SEQ = 8'h04;
  localparam logic [7:0] OFF_EN_HOST = 8'h00;
  localparam logic [7:0] OFF_EN_AUX = 8'h01;
  localparam logic [7:0] OFF_EN_RELAY = 8'h02;
  // ==========================================================
  // reset values and limits
  localparam logic [15:0] RST_DUR = 16'h0001;
  localparam logic [7:0] RST_IVL = 8'h00;
  localparam logic [7:0] RST_MUL = 8'h00;
  localparam logic [7:0] RST_SEQ = 8'h18;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] DUR_MAX = 16'd1439;
  localparam logic [15:0] DUR_SPECIAL = 16'hffff;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] MINUTE_MAX = 8'h59;
  localparam logic [7:0] SEL_MAX = 8'h03;
  localparam logic [7:0] ACT_ON_ALT = 8'hff;
  localparam logic [13:0] MIN_PER_HOUR = 14'd60;
  localparam int NUM_SCHED = 4;
  // ==========================================================
  // indication timing
  localparam int CLK_KHZ = 100000;
  localparam int BLINK_MS = 100;
  localparam int BEEP_SHORT_MS = 100;
  localparam int BEEP_LONG_MS = 1000;
  localparam logic [2:0] IND_PH_REJ = 3'd4;
  typedef enum logic [2:0] {
    IND_IDLE = 3'b001,
    IND_ON = 3'b010,
    IND_OFF = 3'b100
  } ras_ind_t;
endpackage

//--- ras_rtc_model.sv
/*
  rtc stand-in for the scheduler bench: bcd hour/minute and a minute tick.
  assumes the bench pulses step for one cycle, at least ten cycles apart.
*/
`timescale 1ns/1ns
module ras_rtc_model (
  input wire logic core_clk,
  input wire logic load,
  input wire logic step,
  input wire logic [7:0] set_hour,
  input wire logic [7:0] set_minute,
  output logic [7:0] rtc_hour,
  output logic [7:0] rtc_minute,
  output logic rtc_minute_tick
);
  logic [3:0] dly = 4'h0;
  initial begin
    rtc_hour = 8'h00;
    rtc_minute = 8'h00;
    rtc_minute_tick = 1'b0;
  end
  // ==========================================================
  // time and tick
  always @(posedge core_clk) begin
    if (load) begin
      rtc_hour <= set_hour;
      rtc_minute <= set_minute;
    end else if (step) begin
      // no hour carry: the bench never crosses an hour
      rtc_minute <= (rtc_minute[3:0] == 4'h9) ? {rtc_minute[7:4] + 4'h1, 4'h0} : rtc_minute + 8'h01;
    end
    // tick rises two cycles after the time moved, so the time is settled first
    dly <= {dly[2:0], step};
    rtc_minute_tick <= |dly[3:1];
  end
endmodule // ras_rtc_model

//--- ras_sched.sv
/*
  rtc action scheduler: four schedules, range-checked register writes with
  led/beep/message indication, and the action executor driving host power,
  auxiliary supplies and the bistable relay.
  assumes rtc hour/minute and a once-per-minute tick arrive asynchronously;
  the register port is fed by the device's bus decoder.
*/
`timescale 1ns/1ns

// Behaviour
// - start hour accepted only as bcd 0x00..0x23, else rejected.
// - start minute accepted only as bcd 0x00..0x59, else rejected.
// - rejected write blinks all three leds several times with long beep.
// - accepted write blinks leds once with short beep.
// - every accepted or rejected write emits a status message.
// - duration 16 bit at 0x00, 1..1439, reset 1; larger writes ignored.
// - duration 0xffff is a reserved special action, never run.
// - repeat interval byte at 0x02, minutes start to start, reset 0.
// - repeat count byte at 0x03, 0..255, reset 0.
// - zero interval or zero count runs the action once.
// - sequence period byte at 0x04 in hours, reset 24.
// - (duration + interval) * count must be below the sequence period.
// - host power enable byte at 0x00, 0x01 on, 0x00 off.
// - host power on at action start, off after the duration.
// - aux supply enable byte at 0x01 drives aux rails during action.
// - relay enable byte at 0x02 sets the relay during action.
// - one action in many schedules, many actions in one schedule.
// - schedule select 0..3, reset 0, steers per-schedule accesses.
// - run byte 0x01 starts, 0x00 stops, reset stopped.
// - only active schedules execute; 0x00 marks inactive.
module ras_sched #(
  parameter int unsigned BLINK_CYC = ras_pkg::BLINK_MS * ras_pkg::CLK_KHZ,
  parameter int unsigned BEEP_SHORT_CYC = ras_pkg::BEEP_SHORT_MS * ras_pkg::CLK_KHZ,
  parameter int unsigned BEEP_LONG_CYC = ras_pkg::BEEP_LONG_MS * ras_pkg::CLK_KHZ
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_page,
  input wire logic [7:0] reg_off,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [7:0] rtc_hour,
  input wire logic [7:0] rtc_minute,
  input wire logic rtc_minute_tick,
  output logic host_power_on,
  output logic aux_supply_on,
  output logic relay_set,
  output logic [2:0] user_led,
  output logic beeper,
  output logic msg_valid,
  output logic msg_ok
);
  localparam int NS = ras_pkg::NUM_SCHED;

  typedef struct packed {
    logic [1:0] sel;
    logic run;
    logic [NS-1:0] act;
    logic [NS-1:0][7:0] smin, shour;
    logic [NS-1:0][15:0] dur;
    logic [NS-1:0][7:0] ivl, mul, seq;
    logic [NS-1:0] en_host, en_aux, en_relay, started, on;
    logic [NS-1:0][13:0] acnt, scnt;
    logic [NS-1:0][7:0] reps;
    logic tick1, tick2, tick3;
    logic [15:0] time1, time2, rdata;
    ras_pkg::ras_ind_t ind;
    logic [31:0] ind_t;
    logic [2:0] ind_ph;
    logic [31:0] beep_t;
    logic msg_v, msg_k, host, aux, relay;
  } ras_state_t;
  ras_state_t st_r, st_nxt;
  logic wr_hit, wr_ok;
  // ==========================================================
  // next state
  always_comb begin
    logic [1:0] s;
    logic [15:0] dc;
    logic [7:0] ic, mc, sc;
    logic [24:0] prod;
    logic tick;
    s = st_r.sel;
    dc = st_r.dur[st_r.sel];
    ic = st_r.ivl[st_r.sel];
    mc = st_r.mul[st_r.sel];
    sc = st_r.seq[st_r.sel];
    prod = '0;
    tick = st_r.tick2 & ~st_r.tick3;
    st_nxt = st_r;
    wr_hit = 1'b0;
    wr_ok = 1'b0;
    // two-flop synchronisers for the rtc pins
    st_nxt.tick1 = rtc_minute_tick;
    st_nxt.tick2 = st_r.tick1;
    st_nxt.tick3 = st_r.tick2;
    st_nxt.time1 = {rtc_hour, rtc_minute};
    st_nxt.time2 = st_r.time1;
    st_nxt.msg_v = 1'b0;
    // ========================================================
    // register writes with range checks
    if (reg_wr) begin
      wr_hit = 1'b1;
      unique case ({reg_page, reg_off})
        {ras_pkg::PG_CTRL, ras_pkg::OFF_SEL}: wr_ok = reg_wdata[7:0] <= ras_pkg::SEL_MAX;
        {ras_pkg::PG_CTRL, ras_pkg::OFF_RUN}: wr_ok = reg_wdata[7:1] == 7'h00;
        {ras_pkg::PG_START, ras_pkg::OFF_ACTIVE}: wr_ok = reg_wdata[7:1] == 7'h00 ||
                                                    reg_wdata[7:0] == ras_pkg::ACT_ON_ALT;
        {ras_pkg::PG_START, ras_pkg::OFF_MINUTE}: wr_ok = reg_wdata[3:0] <= 4'h9 &&
                                                    reg_wdata[7:0] <= ras_pkg::MINUTE_MAX;
        {ras_pkg::PG_START, ras_pkg::OFF_HOUR}: wr_ok = reg_wdata[3:0] <= 4'h9 &&
                                                  reg_wdata[7:0] <= ras_pkg::HOUR_MAX;
        {ras_pkg::PG_TIME, ras_pkg::OFF_DUR}: begin
          dc = reg_wdata;
          wr_ok = reg_wdata == ras_pkg::DUR_SPECIAL ||
                  (reg_wdata != 16'h0000 && reg_wdata <= ras_pkg::DUR_MAX);
        end
        {ras_pkg::PG_TIME, ras_pkg::OFF_IVL}: begin
          ic = reg_wdata[7:0];
          wr_ok = 1'b1;
        end
        {ras_pkg::PG_TIME, ras_pkg::OFF_MUL}: begin
          mc = reg_wdata[7:0];
          wr_ok = 1'b1;
        end
        {ras_pkg::PG_TIME, ras_pkg::OFF_SEQ}: begin
          sc = reg_wdata[7:0];
          wr_ok = 1'b1;
        end
        {ras_pkg::PG_ACT, ras_pkg::OFF_EN_HOST},
        {ras_pkg::PG_ACT, ras_pkg::OFF_EN_AUX},
        {ras_pkg::PG_ACT, ras_pkg::OFF_EN_RELAY}: wr_ok = reg_wdata[7:1] == 7'h00;
        default: wr_hit = 1'b0;
      endcase
      // total action time below sequence period
      if (reg_page == ras_pkg::PG_TIME && wr_ok) begin
        prod = (25'(dc == ras_pkg::DUR_SPECIAL ? 16'h0000 : dc) + 25'(ic)) * 25'(mc);
        wr_ok = prod < 25'(14'(sc) * ras_pkg::MIN_PER_HOUR);
      end
      if (wr_hit && wr_ok) begin
        unique case ({reg_page, reg_off})
          {ras_pkg::PG_CTRL, ras_pkg::OFF_SEL}: st_nxt.sel = reg_wdata[1:0];
          {ras_pkg::PG_CTRL, ras_pkg::OFF_RUN}: st_nxt.run = reg_wdata[0];
          {ras_pkg::PG_START, ras_pkg::OFF_ACTIVE}: st_nxt.act[s] = reg_wdata[7:0] != 8'h00;
          {ras_pkg::PG_START, ras_pkg::OFF_MINUTE}: st_nxt.smin[s] = reg_wdata[7:0];
          {ras_pkg::PG_START, ras_pkg::OFF_HOUR}: st_nxt.shour[s] = reg_wdata[7:0];
          {ras_pkg::PG_TIME, ras_pkg::OFF_DUR}: st_nxt.dur[s] = reg_wdata;
          {ras_pkg::PG_TIME, ras_pkg::OFF_IVL}: st_nxt.ivl[s] = reg_wdata[7:0];
          {ras_pkg::PG_TIME, ras_pkg::OFF_MUL}: st_nxt.mul[s] = reg_wdata[7:0];
          {ras_pkg::PG_TIME, ras_pkg::OFF_SEQ}: st_nxt.seq[s] = reg_wdata[7:0];
          {ras_pkg::PG_ACT, ras_pkg::OFF_EN_HOST}: st_nxt.en_host[s] = reg_wdata[0];
          {ras_pkg::PG_ACT, ras_pkg::OFF_EN_AUX}: st_nxt.en_aux[s] = reg_wdata[0];
          default: st_nxt.en_relay[s] = reg_wdata[0];
        endcase
      end
    end
    // ========================================================
    // register reads, answered one cycle later
    if (reg_rd) begin
      unique case ({reg_page, reg_off})
        {ras_pkg::PG_CTRL, ras_pkg::OFF_SEL}: st_nxt.rdata = {14'h0000, st_r.sel};
        {ras_pkg::PG_CTRL, ras_pkg::OFF_RUN}: st_nxt.rdata = {15'h0000, st_r.run};
        {ras_pkg::PG_START, ras_pkg::OFF_ACTIVE}: st_nxt.rdata = {15'h0000, st_r.act[s]};
        {ras_pkg::PG_START, ras_pkg::OFF_MINUTE}: st_nxt.rdata = {8'h00, st_r.smin[s]};
        {ras_pkg::PG_START, ras_pkg::OFF_HOUR}: st_nxt.rdata = {8'h00, st_r.shour[s]};
        {ras_pkg::PG_TIME, ras_pkg::OFF_DUR}: st_nxt.rdata = st_r.dur[s];
        {ras_pkg::PG_TIME, ras_pkg::OFF_IVL}: st_nxt.rdata = {8'h00, st_r.ivl[s]};
        {ras_pkg::PG_TIME, ras_pkg::OFF_MUL}: st_nxt.rdata = {8'h00, st_r.mul[s]};
        {ras_pkg::PG_TIME, ras_pkg::OFF_SEQ}: st_nxt.rdata = {8'h00, st_r.seq[s]};
        {ras_pkg::PG_ACT, ras_pkg::OFF_EN_HOST}: st_nxt.rdata = {15'h0000, st_r.en_host[s]};
        {ras_pkg::PG_ACT, ras_pkg::OFF_EN_AUX}: st_nxt.rdata = {15'h0000, st_r.en_aux[s]};
        {ras_pkg::PG_ACT, ras_pkg::OFF_EN_RELAY}: st_nxt.rdata = {15'h0000, st_r.en_relay[s]};
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
    // ========================================================
    // indication: leds, beeper, status message
    unique case (st_r.ind)
      ras_pkg::IND_ON: begin
        st_nxt.ind_t = st_r.ind_t - 32'h0000_0001;
        if (st_r.ind_t == 32'h0000_0000) begin
          st_nxt.ind = (st_r.ind_ph == 3'd0) ? ras_pkg::IND_IDLE : ras_pkg::IND_OFF;
          st_nxt.ind_ph = st_r.ind_ph - 3'd1;
          st_nxt.ind_t = 32'(BLINK_CYC - 1);
        end
      end
      ras_pkg::IND_OFF: begin
        st_nxt.ind_t = st_r.ind_t - 32'h0000_0001;
        if (st_r.ind_t == 32'h0000_0000) begin
          st_nxt.ind = ras_pkg::IND_ON;
          st_nxt.ind_ph = st_r.ind_ph - 3'd1;
          st_nxt.ind_t = 32'(BLINK_CYC - 1);
        end
      end
      default: st_nxt.ind = ras_pkg::IND_IDLE;
    endcase
    if (st_r.beep_t != 32'h0000_0000) begin
      st_nxt.beep_t = st_r.beep_t - 32'h0000_0001;
    end
    // a new entry restarts the indication so the latest outcome is the one shown
    if (wr_hit) begin
      st_nxt.ind = ras_pkg::IND_ON;
      st_nxt.ind_t = 32'(BLINK_CYC - 1);
      st_nxt.ind_ph = wr_ok ? 3'd0 : ras_pkg::IND_PH_REJ;
      st_nxt.beep_t = wr_ok ? 32'(BEEP_SHORT_CYC) : 32'(BEEP_LONG_CYC);
      st_nxt.msg_v = 1'b1;
      st_nxt.msg_k = wr_ok;
    end
    // ========================================================
    // action executor, one per schedule
    for (int i = 0; i < NS; i++) begin
      // stopped or inactive schedules do nothing
      if (!st_r.run || !st_r.act[i]) begin
        st_nxt.started[i] = 1'b0;
        st_nxt.on[i] = 1'b0;
      end else if (tick) begin
        if (!st_r.started[i]) begin
          if (st_r.time2 == {st_r.shour[i], st_r.smin[i]}) begin
            st_nxt.started[i] = 1'b1;
            st_nxt.on[i] = 1'b1;
            st_nxt.acnt[i] = 14'd0;
            st_nxt.scnt[i] = 14'd0;
            st_nxt.reps[i] = 8'd1;
          end
        end else begin
          st_nxt.acnt[i] = st_r.acnt[i] + 14'd1;
          st_nxt.scnt[i] = st_r.scnt[i] + 14'd1;
          // off once the duration has elapsed
          if (16'(st_r.acnt[i]) + 16'd1 == st_r.dur[i]) begin
            st_nxt.on[i] = 1'b0;
          end
          if (st_r.scnt[i] + 14'd1 == 14'(14'(st_r.seq[i]) * ras_pkg::MIN_PER_HOUR)) begin
            st_nxt.on[i] = 1'b1;
            st_nxt.acnt[i] = 14'd0;
            st_nxt.scnt[i] = 14'd0;
            st_nxt.reps[i] = 8'd1;
          // repeat only with nonzero interval and count
          end else if (st_r.ivl[i] != 8'h00 && st_r.mul[i] != 8'h00 &&
                       st_r.acnt[i] + 14'd1 == 14'(st_r.ivl[i]) &&
                       st_r.reps[i] < st_r.mul[i]) begin
            st_nxt.on[i] = 1'b1;
            st_nxt.acnt[i] = 14'd0;
            st_nxt.reps[i] = st_r.reps[i] + 8'd1;
          end
        end
      end
      // the reserved duration never drives an action
      if (st_r.dur[i] == ras_pkg::DUR_SPECIAL) begin
        st_nxt.on[i] = 1'b0;
      end
    end
    // any schedule may drive any action
    st_nxt.host = |(st_nxt.on & st_r.en_host);
    st_nxt.aux = |(st_nxt.on & st_r.en_aux);
    st_nxt.relay = |(st_nxt.on & st_r.en_relay);
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.ind <= ras_pkg::IND_IDLE;
      for (int i = 0; i < NS; i++) begin
        st_r.dur[i] <= ras_pkg::RST_DUR;
        st_r.ivl[i] <= ras_pkg::RST_IVL;
        st_r.mul[i] <= ras_pkg::RST_MUL;
        st_r.seq[i] <= ras_pkg::RST_SEQ;
        st_r.smin[i] <= ras_pkg::RST_BYTE;
        st_r.shour[i] <= ras_pkg::RST_BYTE;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign host_power_on = st_r.host;
  assign aux_supply_on = st_r.aux;
  assign relay_set = st_r.relay;
  assign user_led = {3{st_r.ind == ras_pkg::IND_ON}};
  assign beeper = st_r.beep_t != 32'h0000_0000;
  assign msg_valid = st_r.msg_v;
  assign msg_ok = st_r.msg_k;

  // ==========================================================
  // checks
  a_hour_reject: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr && reg_page == ras_pkg::PG_START && reg_off == ras_pkg::OFF_HOUR &&
    reg_wdata[7:0] > ras_pkg::HOUR_MAX |=> msg_valid && !msg_ok)
    else $error("out of range hour accepted");
  a_minute_reject: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr && reg_page == ras_pkg::PG_START && reg_off == ras_pkg::OFF_MINUTE &&
    reg_wdata[7:0] > ras_pkg::MINUTE_MAX |=> msg_valid && !msg_ok)
    else $error("out of range minute accepted");
  a_reject_show: assert property (@(posedge core_clk) disable iff (sys_rst)
    msg_valid && !msg_ok |-> user_led == 3'b111 && beeper)
    else $error("reject not indicated");
  a_accept_show: assert property (@(posedge core_clk) disable iff (sys_rst)
    msg_valid && msg_ok |-> user_led == 3'b111 && beeper && st_r.ind_ph == 3'd0)
    else $error("accept not indicated as single blink");
  a_msg_each: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_hit |=> msg_valid && msg_ok == $past(wr_ok))
    else $error("status message missing");
  a_dur_ignore: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr && reg_page == ras_pkg::PG_TIME && reg_off == ras_pkg::OFF_DUR &&
    reg_wdata > ras_pkg::DUR_MAX && reg_wdata != ras_pkg::DUR_SPECIAL
    |=> !msg_ok && $stable(st_r.dur))
    else $error("oversized duration stored");
  a_special_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_r.dur[0] == ras_pkg::DUR_SPECIAL |=> !st_r.on[0])
    else $error("reserved duration ran an action");
  a_once_only: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_r.started[0] && (st_r.ivl[0] == 8'h00 || st_r.mul[0] == 8'h00) |-> st_r.reps[0] <= 8'd1)
    else $error("action repeated without interval or count");
  a_run_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    !st_r.run |=> !host_power_on && !aux_supply_on && !relay_set)
    else $error("action while scheduler stopped");
endmodule // ras_sched

//--- ras_sched_tb_top.sv
/*
  self-checking bench of the rtc action scheduler: registers, range checks,
  indication, and action execution against the rtc model.
  assumes shortened indication counts are handed to the design.
*/
`timescale 1ns/1ns
module ras_sched_tb_top;
  localparam int BLK = 4;
  localparam int BSH = 3;
  localparam int BLG = 20;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] reg_page = 7'h00;
  logic [7:0] reg_off = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [7:0] rtc_hour;
  logic [7:0] rtc_minute;
  logic rtc_minute_tick;
  logic host_power_on;
  logic aux_supply_on;
  logic relay_set;
  logic [2:0] user_led;
  logic beeper;
  logic msg_valid;
  logic msg_ok;
  logic load = 1'b0;
  logic step = 1'b0;
  logic [7:0] set_hour = 8'h00;
  logic [7:0] set_minute = 8'h00;
  logic rd_q1 = 1'b0;
  logic rd_q2 = 1'b0;
  logic exp_ok_q[$];
  logic [15:0] exp_rd_q[$];
  int err_count = 0;
  int comparisons = 0;

  always #5 core_clk = ~core_clk;

  ras_sched #(.BLINK_CYC(BLK), .BEEP_SHORT_CYC(BSH), .BEEP_LONG_CYC(BLG)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_page(reg_page), .reg_off(reg_off), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rtc_hour(rtc_hour), .rtc_minute(rtc_minute), .rtc_minute_tick(rtc_minute_tick),
    .host_power_on(host_power_on), .aux_supply_on(aux_supply_on), .relay_set(relay_set),
    .user_led(user_led), .beeper(beeper), .msg_valid(msg_valid), .msg_ok(msg_ok));

  ras_rtc_model rtc (.core_clk(core_clk), .load(load), .step(step), .set_hour(set_hour),
    .set_minute(set_minute), .rtc_hour(rtc_hour), .rtc_minute(rtc_minute),
    .rtc_minute_tick(rtc_minute_tick));

  // ==========================================================
  // compare, verdict, bus tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // m: 1 accepted, 0 refused, 2 unmapped (no message expected)
  task automatic wr(input logic [6:0] pg, input logic [7:0] off, input logic [15:0] d, input int m);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_page = pg;
    reg_off = off;
    reg_wdata = d;
    if (m < 2) exp_ok_q.push_back(m == 1);
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [6:0] pg, input logic [7:0] off, input logic [15:0] e);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_page = pg;
    reg_off = off;
    exp_rd_q.push_back(e);
    @(negedge core_clk);
    reg_rd = 1'b0;
  endtask

  task automatic ind(input int rises, input int on_cyc, input int beep_cyc);
    int r = 0;
    int n = 0;
    int b = 0;
    logic prev = 1'b0;
    // sample before waiting: the write's last negedge already shows the first lit cycle
    repeat (40) begin
      if (user_led === 3'b111 && !prev) r++;
      if (user_led === 3'b111) n++;
      prev = (user_led === 3'b111);
      if (beeper === 1'b1) b++;
      @(negedge core_clk);
    end
    chk("led blinks", 16'(rises), 16'(r));
    chk("led on cycles", 16'(on_cyc), 16'(n));
    chk("beep cycles", 16'(beep_cyc), 16'(b));
  endtask

  task automatic tick_chk(input logic [2:0] e);
    @(negedge core_clk);
    step = 1'b1;
    @(negedge core_clk);
    step = 1'b0;
    repeat (12) @(negedge core_clk);
    chk("host aux relay", {13'h0, e}, {13'h0, host_power_on, aux_supply_on, relay_set});
  endtask

  // ==========================================================
  // result monitor: oldest note against each result
  always @(posedge core_clk) begin
    rd_q1 <= reg_rd;
    rd_q2 <= rd_q1;
  end
  always @(negedge core_clk) begin
    if (msg_valid === 1'b1 && exp_ok_q.size() == 0) chk("unexpected message", 16'h0000, 16'h0001);
    else if (msg_valid === 1'b1) chk("msg_ok", {15'h0, exp_ok_q.pop_front()}, {15'h0, msg_ok});
    if (rd_q2) chk("reg_rdata", exp_rd_q.pop_front(), reg_rdata);
  end

  initial begin
    #100000;
    err_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    close_out();
  end

  // ==========================================================
  // tests
  initial begin
    logic [7:0] h;
    int k;
    k = $urandom(71);
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    rd(ras_pkg::PG_CTRL, ras_pkg::OFF_SEL, 16'h0000);
    rd(ras_pkg::PG_CTRL, ras_pkg::OFF_RUN, 16'h0000);
    rd(ras_pkg::PG_START, ras_pkg::OFF_ACTIVE, 16'h0000);
    rd(ras_pkg::PG_TIME, ras_pkg::OFF_DUR, 16'h0001);
    rd(ras_pkg::PG_TIME, ras_pkg::OFF_IVL, 16'h0000);
    rd(ras_pkg::PG_TIME, ras_pkg::OFF_MUL, 16'h0000);
    rd(ras_pkg::PG_TIME, ras_pkg::OFF_SEQ, 16'h0018);
    for (k = 0; k < 3; k++) rd(ras_pkg::PG_ACT, 8'(k), 16'h0000);
    rd(ras_pkg::PG_CTRL, 8'h20, 16'h0000);
    $display("test reset values done");
    wr(ras_pkg::PG_START, ras_pkg::OFF_HOUR, 16'h0023, 1);
    wr(ras_pkg::PG_START, ras_pkg::OFF_HOUR, 16'h0024, 0);
    wr(ras_pkg::PG_START, ras_pkg::OFF_HOUR, 16'h001a, 0);
    rd(ras_pkg::PG_START, ras_pkg::OFF_HOUR, 16'h0023);
    wr(ras_pkg::PG_START, ras_pkg::OFF_MINUTE, 16'h0059, 1);
    wr(ras_pkg::PG_START, ras_pkg::OFF_MINUTE, 16'h0060, 0);
    wr(ras_pkg::PG_START, ras_pkg::OFF_MINUTE, 16'h003a, 0);
    rd(ras_pkg::PG_START, ras_pkg::OFF_MINUTE, 16'h0059);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_DUR, 16'd1439, 1);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_DUR, 16'd1440, 0);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_DUR, 16'h0000, 0);
    rd(ras_pkg::PG_TIME, ras_pkg::OFF_DUR, 16'd1439);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_DUR, 16'hffff, 1);
    wr(ras_pkg::PG_CTRL, ras_pkg::OFF_SEL, 16'h0004, 0);
    wr(ras_pkg::PG_CTRL, ras_pkg::OFF_RUN, 16'h0002, 0);
    wr(ras_pkg::PG_ACT, ras_pkg::OFF_EN_HOST, 16'h0002, 0);
    wr(ras_pkg::PG_TIME, 8'h07, 16'h0005, 2);
    for (k = 0; k < 8; k++) begin
      h[7:4] = 4'($urandom % 3);
      h[3:0] = 4'((h[7:4] == 4'h2) ? $urandom % 4 : $urandom % 10);
      wr(ras_pkg::PG_START, ras_pkg::OFF_HOUR, {8'h00, h}, 1);
      rd(ras_pkg::PG_START, ras_pkg::OFF_HOUR, {8'h00, h});
    end
    $display("test range checks done");
    wr(ras_pkg::PG_START, ras_pkg::OFF_HOUR, 16'h0012, 1);
    ind(1, BLK, BSH);
    wr(ras_pkg::PG_START, ras_pkg::OFF_HOUR, 16'h0030, 0);
    ind(3, 3 * BLK, BLG);
    $display("test indication done");
    // (duration + interval) * count must stay below the sequence period
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_DUR, 16'd20, 1);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_MUL, 16'h0002, 1);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_IVL, 16'h0009, 1);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_SEQ, 16'h0001, 1);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_IVL, 16'h000a, 0);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_MUL, 16'h0003, 0);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_DUR, 16'd21, 0);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_SEQ, 16'h0000, 0);
    rd(ras_pkg::PG_TIME, ras_pkg::OFF_IVL, 16'h0009);
    $display("test total time check done");
    // schedule 0 at 12:01: host and relay, twice, 3 minutes apart
    wr(ras_pkg::PG_START, ras_pkg::OFF_ACTIVE, 16'h0001, 1);
    wr(ras_pkg::PG_START, ras_pkg::OFF_MINUTE, 16'h0001, 1);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_DUR, 16'h0002, 1);
    wr(ras_pkg::PG_TIME, ras_pkg::OFF_IVL, 16'h0003, 1);
    wr(ras_pkg::PG_ACT, ras_pkg::OFF_EN_HOST, 16'h0001, 1);
    wr(ras_pkg::PG_ACT, ras_pkg::OFF_EN_RELAY, 16'h0001, 1);
    // schedule 1 at 12:02 shares host power and adds aux; schedule 2 stays inactive
    for (k = 1; k < 3; k++) begin
      wr(ras_pkg::PG_CTRL, ras_pkg::OFF_SEL, 16'(k), 1);
      if (k == 1) wr(ras_pkg::PG_START, ras_pkg::OFF_ACTIVE, 16'h00ff, 1);
      rd(ras_pkg::PG_START, ras_pkg::OFF_ACTIVE, (k == 1) ? 16'h0001 : 16'h0000);
      wr(ras_pkg::PG_START, ras_pkg::OFF_HOUR, 16'h0012, 1);
      wr(ras_pkg::PG_START, ras_pkg::OFF_MINUTE, (k == 1) ? 16'h0002 : 16'h0001, 1);
      wr(ras_pkg::PG_ACT, ras_pkg::OFF_EN_HOST, 16'h0001, 1);
      wr(ras_pkg::PG_ACT, ras_pkg::OFF_EN_AUX, 16'h0001, 1);
    end
    @(negedge core_clk);
    set_hour = 8'h12;
    load = 1'b1;
    @(negedge core_clk);
    load = 1'b0;
    wr(ras_pkg::PG_CTRL, ras_pkg::OFF_RUN, 16'h0001, 1);
    tick_chk(3'b101);
    tick_chk(3'b111);
    tick_chk(3'b000);
    tick_chk(3'b101);
    tick_chk(3'b101);
    tick_chk(3'b000);
    tick_chk(3'b000);
    $display("test action run done");
    wr(ras_pkg::PG_CTRL, ras_pkg::OFF_RUN, 16'h0000, 1);
    tick_chk(3'b000);
    repeat (4) @(negedge core_clk);
    chk("notes left", 16'h0000, 16'(exp_ok_q.size() + exp_rd_q.size()));
    $display("test stop done");
    close_out();
  end
endmodule // ras_sched_tb_top
